// *** hdl/eep_page_ctrl.sv ***
// page programming controller for the on-chip data nonvolatile memory
//
// Operation
// - With the space selected and not busy, a data write lands in the column latch slot only.
// - The column latch holds one 128 byte page, filled byte by byte.
// - The row programmed is the page of the last latch write before launch.
// - A latch write to a new page drops all bytes loaded under the old page.
// - Writing code 5xh then Axh to the control register starts programming.
// - Any access between the two code writes aborts the launch.
// - A valid launch sets the busy flag for the whole array write.
// - While busy, array reads are not served.
// - Busy clears by hardware when programming ends, the only done signal.
// - With the space selected, a data read returns the stored array byte.
// - The 11 bit address splits into a 4 bit row and a 7 bit byte index.
// - Each loaded byte gets a marker, only marked bytes program, all clear after.
// - The space spans 0000h to 07FFh and is routed only while selected.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module eep_page_ctrl
	import eep_pkg::*;
#(
	parameter int PAGE_BYTES_P  = PAGE_BYTES,
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	input  wire logic               sys_clk_i,   // system clock
	input  wire logic               sys_rst_i,   // sync reset, high
	input  wire logic [REG_AW-1:0]  reg_addr_i,  // register address
	input  wire logic [DATA_W-1:0]  reg_wdata_i, // register write data
	input  wire logic               reg_wr_i,    // register write strobe
	input  wire logic               reg_rd_i,    // register read strobe
	output logic      [DATA_W-1:0]  reg_rdata_o, // register read data
	input  wire logic [XADDR_W-1:0] xd_addr_i,   // data pointer address
	input  wire logic [DATA_W-1:0]  xd_wdata_i,  // data move write byte
	input  wire logic               xd_wr_i,     // data move write strobe
	input  wire logic               xd_rd_i,     // data move read strobe
	output logic      [DATA_W-1:0]  xd_rdata_o,  // data move read byte
	output logic                    xd_hit_o,    // read claimed by array
	output logic                    busy_o,      // programming in progress
	output logic                    sel_o        // space select state
);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	localparam int CNT_W = $clog2(PROG_CYCLES_P + 1);

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_XFER = 2'b01,
		PH_WAIT = 2'b11
	} eep_phase_t;

	typedef struct packed {
		logic                    sel;
		logic                    busy;
		logic                    armed;
		logic [PAGE_W-1:0]       page;
		logic [PAGE_BYTES_P-1:0] marks;
		eep_phase_t              phase;
		logic [BYTE_W-1:0]       idx;
		logic [CNT_W-1:0]        cnt;
		logic [DATA_W-1:0]       reg_rdata;
		logic [DATA_W-1:0]       xd_rdata;
		logic                    xd_hit;
	} eep_state_t;

	localparam logic [BYTE_W-1:0] IDX_LAST =
		BYTE_W'(PAGE_BYTES_P - 1);
	localparam logic [CNT_W-1:0]  CNT_LOAD =
		CNT_W'(PROG_CYCLES_P - 1);

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	eep_state_t            s_reg;
	eep_state_t            s_next;
	logic [DATA_W-1:0]     latch_mem [0:PAGE_BYTES_P-1];
	logic                  nv_hit;
	logic                  latch_we;
	logic                  ctrl_wr;
	logic                  ctrl_rd;
	logic [3:0]            code;
	logic                  other_acc;
	logic [BYTE_W-1:0]     xd_byte;
	logic [PAGE_W-1:0]     xd_page;
	logic                  arr_we;
	logic [NV_ADDR_W-1:0]  arr_waddr;
	logic [DATA_W-1:0]     arr_wdata;
	logic [NV_ADDR_W-1:0]  arr_raddr;
	logic [DATA_W-1:0]     arr_rdata;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// window and select
	assign nv_hit = s_reg.sel && (xd_addr_i >= NV_BASE)
		&& (xd_addr_i <= NV_LAST);
	assign xd_byte = xd_addr_i[BYTE_W-1:0];
	assign xd_page = xd_addr_i[NV_ADDR_W-1:BYTE_W];

	assign latch_we = xd_wr_i && nv_hit && !s_reg.busy;

	assign ctrl_wr   = reg_wr_i && (reg_addr_i == CTRL_OFS);
	assign ctrl_rd   = reg_rd_i && (reg_addr_i == CTRL_OFS);
	assign code      = reg_wdata_i[CODE_MSB:CODE_LSB];
	assign other_acc = xd_wr_i || xd_rd_i || reg_rd_i
		|| (reg_wr_i && !ctrl_wr);

	// ------------------------------------------------------------
	// array ports
	// ------------------------------------------------------------
	// only marked bytes program
	assign arr_we    = (s_reg.phase == PH_XFER)
		&& s_reg.marks[s_reg.idx];
	assign arr_waddr = {s_reg.page, s_reg.idx};
	assign arr_wdata = latch_mem[s_reg.idx];
	assign arr_raddr = xd_addr_i[NV_ADDR_W-1:0];

	eep_mem_array #(
		.AW (NV_ADDR_W),
		.DW (DATA_W)
	) u_array (
		.sys_clk_i (sys_clk_i),
		.we_i      (arr_we),
		.waddr_i   (arr_waddr),
		.wdata_i   (arr_wdata),
		.raddr_i   (arr_raddr),
		.rdata_o   (arr_rdata)
	);

	// ------------------------------------------------------------
	// column latch storage
	// ------------------------------------------------------------
	// one page of byte slots
	always_ff @(posedge sys_clk_i) begin
		if (latch_we) begin
			latch_mem[xd_byte] <= xd_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next           = s_reg;
		s_next.reg_rdata = UNMAP_RD_VAL;
		s_next.xd_rdata  = UNMAP_RD_VAL;
		s_next.xd_hit    = 1'b0;

		if (latch_we) begin
			s_next.page = xd_page;
			if (xd_page != s_reg.page) begin
				s_next.marks          = '0;
				s_next.marks[xd_byte] = 1'b1;
			end else begin
				s_next.marks[xd_byte] = 1'b1;
			end
		end

		if (xd_rd_i && nv_hit) begin
			s_next.xd_hit = 1'b1;
			if (s_reg.busy) begin
				s_next.xd_rdata = BUSY_RD_VAL;
			end else begin
				s_next.xd_rdata = arr_rdata;
			end
		end

		if (other_acc) begin
			s_next.armed = 1'b0;
		end

		if (ctrl_wr) begin
			s_next.sel = reg_wdata_i[CTRL_SEL_BIT];
			if (s_reg.armed && (code == CODE_GO)
				&& !s_reg.busy) begin
				s_next.busy  = 1'b1;
				s_next.armed = 1'b0;
				s_next.phase = PH_XFER;
				s_next.idx   = '0;
			end else begin
				s_next.armed = (code == CODE_ARM)
					&& !s_reg.busy;
			end
		end

		if (ctrl_rd) begin
			s_next.reg_rdata                = '0;
			s_next.reg_rdata[CTRL_BUSY_BIT] = s_reg.busy;
			s_next.reg_rdata[CTRL_SEL_BIT]  = s_reg.sel;
		end

		unique case (s_reg.phase)
			PH_IDLE: begin
				s_next.cnt = '0;
			end
			PH_XFER: begin
				if (s_reg.idx == IDX_LAST) begin
					s_next.phase = PH_WAIT;
					s_next.cnt   = CNT_LOAD;
				end else begin
					s_next.idx = s_reg.idx + 1'b1;
				end
			end
			PH_WAIT: begin
				if (s_reg.cnt == '0) begin
					s_next.busy  = 1'b0;
					s_next.phase = PH_IDLE;
					s_next.marks = '0;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			default: begin
				s_next.phase = PH_IDLE;
				s_next.busy  = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s_reg       <= '0;
			s_reg.sel   <= CTRL_RST[CTRL_SEL_BIT];
			s_reg.busy  <= CTRL_RST[CTRL_BUSY_BIT];
			s_reg.phase <= PH_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_o = s_reg.reg_rdata;
	assign xd_rdata_o  = s_reg.xd_rdata;
	assign xd_hit_o    = s_reg.xd_hit;
	assign busy_o      = s_reg.busy;
	assign sel_o       = s_reg.sel;

endmodule

`default_nettype wire

// *** inc/eep_pkg.sv ***
// constants shared by the nonvolatile data page controller
`default_nettype none

package eep_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS  = 20000;
	localparam int PROG_CYCLES   =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int XADDR_W    = 16;
	localparam int REG_AW     = 8;
	localparam int NV_ADDR_W  = 11;
	localparam int PAGE_W     = 4;
	localparam int BYTE_W     = 7;
	localparam int PAGE_BYTES = 128;

	// ------------------------------------------------------------
	// data space window
	// ------------------------------------------------------------
	localparam logic [XADDR_W-1:0] NV_BASE = 16'h0000;
	localparam logic [XADDR_W-1:0] NV_LAST = 16'h07FF;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	localparam logic [REG_AW-1:0] CTRL_OFS      = 8'h00;
	localparam int                CTRL_BUSY_BIT = 0;
	localparam int                CTRL_SEL_BIT  = 1;
	localparam logic [DATA_W-1:0] CTRL_RST      = 8'h00;
	localparam int                CODE_MSB      = 7;
	localparam int                CODE_LSB      = 4;
	localparam logic [3:0]        CODE_ARM      = 4'h5;
	localparam logic [3:0]        CODE_GO       = 4'hA;

	// ------------------------------------------------------------
	// read answers
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] BUSY_RD_VAL  = 8'hFF;
	localparam logic [DATA_W-1:0] UNMAP_RD_VAL = 8'h00;

endpackage

`default_nettype wire

// *** hdl/eep_mem_array.sv ***
// nonvolatile byte array model with one write and one async read port
`timescale 1ns/100ps
`default_nettype none

module eep_mem_array #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input  wire logic          sys_clk_i, // system clock
	input  wire logic          we_i,      // write enable
	input  wire logic [AW-1:0] waddr_i,   // write address
	input  wire logic [DW-1:0] wdata_i,   // write data
	input  wire logic [AW-1:0] raddr_i,   // read address
	output logic      [DW-1:0] rdata_o    // read data, combinational
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem[raddr_i];

endmodule

`default_nettype wire

// *** verif/eep_page_ctrl_sva.sv ***
// port assertions for the page controller
`timescale 1ns/100ps
`default_nettype none
module eep_page_ctrl_sva
	import eep_pkg::*;
#(
	parameter int PROG_CYCLES_P = 4
) (
	input wire logic		sys_clk_i,	// clock
	input wire logic		sys_rst_i,	// reset
	input wire logic [REG_AW-1:0]	reg_addr_i,	// reg addr
	input wire logic [DATA_W-1:0]	reg_wdata_i,	// reg data
	input wire logic		reg_wr_i,	// reg write
	input wire logic		reg_rd_i,	// reg read
	input wire logic [DATA_W-1:0]	reg_rdata_o,	// reg rdata
	input wire logic [XADDR_W-1:0]	xd_addr_i,	// pointer
	input wire logic [DATA_W-1:0]	xd_wdata_i,	// move data
	input wire logic		xd_wr_i,	// move write
	input wire logic		xd_rd_i,	// move read
	input wire logic [DATA_W-1:0]	xd_rdata_o,	// move rdata
	input wire logic		xd_hit_o,	// hit
	input wire logic		busy_o,		// busy
	input wire logic		sel_o		// select
);
	// one busy cycle per slot, then the wait count
	localparam int BUSY_N = PAGE_BYTES + PROG_CYCLES_P;
	wire logic win = sel_o && xd_addr_i <= NV_LAST;
	wire logic ctl = reg_wr_i && reg_addr_i == CTRL_OFS;
	wire logic arm = ctl && reg_wdata_i[7:4] == CODE_ARM && !busy_o;
	wire logic go = ctl && reg_wdata_i[7:4] == CODE_GO;
	wire logic stb = reg_wr_i || reg_rd_i || xd_wr_i || xd_rd_i;
	int	cnt;
	logic	armed;
	// busy cycle count and launch arming
	always_ff @(posedge sys_clk_i) begin
		cnt <= (sys_rst_i || !busy_o) ? 0 : cnt + 1;
		armed <= !sys_rst_i && (arm || (armed && !stb));
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_ctrl_read_back: assert property (
		reg_rd_i && reg_addr_i == CTRL_OFS |=>
		reg_rdata_o == {6'h00, $past(sel_o), $past(busy_o)})
		else $error("bad control read");
	a_hit_cause: assert property (
		xd_hit_o |-> $past(xd_rd_i && win)) else $error("stray hit");
	a_busy_blocks: assert property (
		xd_rd_i && win && busy_o |=> xd_hit_o && xd_rdata_o == BUSY_RD_VAL)
		else $error("read served busy");
	a_window_miss: assert property (
		xd_rd_i && !win |=> !xd_hit_o && xd_rdata_o == UNMAP_RD_VAL)
		else $error("bad window");
	a_launch_go: assert property (
		armed && go |=> busy_o) else $error("launch missed");
	a_only_launch: assert property (
		$rose(busy_o) |-> $past(armed && go)) else $error("false launch");
	a_busy_length: assert property (
		$fell(busy_o) |-> cnt == BUSY_N) else $error("busy length");
	a_busy_bounded: assert property (
		busy_o |-> cnt < BUSY_N) else $error("busy too long");
endmodule
bind eep_page_ctrl eep_page_ctrl_sva #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_sva (.*);
`default_nettype wire

// *** verif/eep_cpu_model.sv ***
// processor core model issuing control and data moves
`timescale 1ns/100ps
`default_nettype none
module eep_cpu_model
	import eep_pkg::*;
(
	input  wire logic		clk_i,	// clock
	input  wire logic [DATA_W-1:0]	rrd_i,	// reg rdata
	input  wire logic [DATA_W-1:0]	xrd_i,	// move rdata
	input  wire logic		hit_i,	// hit
	input  wire logic		busy_i,	// busy
	output logic [REG_AW-1:0]	ra_o,	// reg addr
	output logic [DATA_W-1:0]	wd_o,	// write byte
	output logic			rw_o,	// reg write
	output logic			rr_o,	// reg read
	output logic [XADDR_W-1:0]	xa_o,	// pointer
	output logic			xw_o,	// move write
	output logic			xr_o	// move read
);
	initial {ra_o, wd_o, rw_o, rr_o, xa_o, xw_o, xr_o} = '0;
	task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		ra_o <= a;
		wd_o <= d;
		rw_o <= 1'b1;
		@(posedge clk_i);
		rw_o <= 1'b0;
		wd_o <= ~d;
	endtask
	task automatic reg_r(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_i);
		ra_o <= a;
		rr_o <= 1'b1;
		@(posedge clk_i);
		rr_o <= 1'b0;
		#1 q = rrd_i;
	endtask
	task automatic xd_w(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		xa_o <= a;
		wd_o <= d;
		xw_o <= 1'b1;
		@(posedge clk_i);
		xw_o <= 1'b0;
		wd_o <= ~d;
	endtask
	task automatic xd_r(input logic [15:0] a, output logic h,
		output logic [7:0] q);
		@(posedge clk_i);
		xa_o <= a;
		xr_o <= 1'b1;
		@(posedge clk_i);
		xr_o <= 1'b0;
		#1 h = hit_i;
		q = xrd_i;
	endtask
	task automatic launch();
		reg_w(CTRL_OFS, 8'h52);
		reg_w(CTRL_OFS, 8'hA2);
	endtask
	task automatic wait_idle(output int n);
		n = 0;
		#1;
		while (busy_i === 1'b1 && n < 1000) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask
endmodule
`default_nettype wire

// *** verif/eep_page_ctrl_tb.sv ***
// self-checking bench for the page controller
`timescale 1ns/100ps
`default_nettype none
module eep_page_ctrl_tb;
	import eep_pkg::*;
	localparam int PC = 4;
	logic		sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i;
	logic		xd_wr_i, xd_rd_i, xd_hit_o, busy_o, sel_o, h;
	logic [7:0]	reg_addr_i, reg_wdata_i, reg_rdata_o, xd_rdata_o, v;
	logic [15:0]	xd_addr_i;
	int		err_total = 0;
	int		num_checks = 0;
	int		n;
	eep_page_ctrl #(.PROG_CYCLES_P(PC)) dut (.*, .xd_wdata_i(reg_wdata_i));
	eep_cpu_model cpu (.clk_i(sys_clk_i), .rrd_i(reg_rdata_o),
		.xrd_i(xd_rdata_o), .hit_i(xd_hit_o), .busy_i(busy_o),
		.ra_o(reg_addr_i), .wd_o(reg_wdata_i), .rw_o(reg_wr_i),
		.rr_o(reg_rd_i), .xa_o(xd_addr_i), .xw_o(xd_wr_i), .xr_o(xd_rd_i));
	task automatic tally_and_finish();
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic eh,
		input logic [7:0] ev);
		cpu.xd_r(a, h, v);
		chk({7'h00, h}, {7'h00, eh});
		chk(v, ev);
	endtask
	task automatic creg(input logic [7:0] ev);
		cpu.reg_r(CTRL_OFS, v);
		chk(v, ev);
		@(posedge sys_clk_i);
		#1;
		chk(reg_rdata_o, 8'h00);
	endtask
	task automatic idle();
		cpu.wait_idle(n);
		if (n >= 1000) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic t_regs();
		creg(CTRL_RST);
		rd(16'h0105, 1'b0, 8'h00);
		cpu.reg_w(CTRL_OFS, 8'h02);
		creg(8'h02);
		cpu.reg_r(8'h01, v);
		chk(v, UNMAP_RD_VAL);
		rd(16'h0800, 1'b0, 8'h00);
	endtask
	task automatic t_prog();
		cpu.xd_w(16'h0100, 8'h3C);
		cpu.xd_w(16'h0101, 8'h11);
		cpu.xd_w(16'h017F, 8'hE7);
		cpu.launch();
		idle();
		chk(8'(n), 8'(PAGE_BYTES + PC));
		rd(16'h0100, 1'b1, 8'h3C);
		rd(16'h0101, 1'b1, 8'h11);
		rd(16'h017F, 1'b1, 8'hE7);
		cpu.xd_w(16'h0100, 8'h5A);
		rd(16'h0100, 1'b1, 8'h3C);
		cpu.launch();
		rd(16'h0100, 1'b1, BUSY_RD_VAL);
		creg(8'h03);
		cpu.xd_w(16'h0101, 8'h99);
		idle();
		creg(8'h02);
		rd(16'h0100, 1'b1, 8'h5A);
		rd(16'h0101, 1'b1, 8'h11);
	endtask
	task automatic t_abort();
		cpu.xd_w(16'h0104, 8'h44);
		cpu.reg_w(CTRL_OFS, 8'h52);
		cpu.xd_r(16'h0104, h, v);
		cpu.reg_w(CTRL_OFS, 8'hA2);
		creg(8'h02);
		cpu.reg_w(CTRL_OFS, 8'h52);
		cpu.reg_w(8'h01, 8'h00);
		cpu.reg_w(CTRL_OFS, 8'hA2);
		creg(8'h02);
	endtask
	task automatic t_pages();
		cpu.xd_w(16'h0181, 8'hAA);
		cpu.xd_w(16'h0103, 8'hBB);
		cpu.launch();
		idle();
		rd(16'h0103, 1'b1, 8'hBB);
		rd(16'h0101, 1'b1, 8'h11);
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		sys_rst_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_prog();
		t_abort();
		t_pages();
		tally_and_finish();
	end
endmodule
`default_nettype wire
